// ---- logic/plc_word_logic_pkg.sv ----
// Purpose: Shared constants for the word logic and error unit
// Assumes: 16-bit words, digit designation in nibbles
// Notes: Error codes are decimal figures stored in a 16-bit code register
package plc_word_logic_pkg;
  localparam int WORD_W = 16;
  localparam int DIGIT_W = 3;
  localparam int STEP_W = 16;
  localparam int NIBBLE_W = 4;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [WORD_W-1:0] ERR_NONE = 16'h0000;
  localparam logic [WORD_W-1:0] ERR_UNDECODABLE = 16'h000A;
  localparam logic [WORD_W-1:0] ERR_PARAMETER = 16'h000B;
  localparam logic [WORD_W-1:0] ERR_SCAN_OVERRUN = 16'h0016;
  localparam logic [WORD_W-1:0] ERR_MISSING_END = 16'h0018;
  localparam logic [DIGIT_W-1:0] DIGITS_FULL = 3'h4;
  localparam logic [STEP_W-1:0] STEP_ZERO = 16'h0000;
  localparam int WDT_LIMIT_DEFAULT = 200;

  typedef enum logic [2:0]
  {
    OP_NONE = 3'b000,
    OP_XNOR2 = 3'b001,
    OP_XNOR3 = 3'b010,
    OP_NEGATE = 3'b011,
    OP_BAD = 3'b111
  } op_sel_t;

  typedef enum logic [1:0]
  {
    ST_STOP = 2'b00,
    ST_RUN = 2'b01,
    ST_HALT = 2'b10
  } run_state_t;
endpackage : plc_word_logic_pkg

// ---- logic/plc_word_logic_and_error_unit.sv ----
// Purpose: Word XNOR / negate datapath with self-diagnostic error capture
// Assumes: One instruction presented per cycle, decoded upstream
// Notes: Results leave on a registered write port with a one-cycle strobe
// Function
// - Two-operand XNOR combines source and destination and writes the 16-bit result back.
// - Three-operand XNOR combines two sources and writes the 16-bit result to the destination.
// - Bits above the designated digit count (1 to 4 nibbles) of a bit operand read as zero.
// - Negate replaces the word with its two's complement.
// - An error during run records its code and step and raises the error indication.
// - An undecodable instruction records code 10 and stops.
// - A parameter check at power-on and stop-to-run failing records code 11 and stops.
// - A scan time above the watchdog limit at end of scan records code 22 and stops.
// - An end instruction read as another code records code 24 and stops.
`timescale 1ns/1ps
module plc_word_logic_and_error_unit #(
  parameter int WDT_LIMIT = plc_word_logic_pkg::WDT_LIMIT_DEFAULT
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic run_req_in,
  input wire logic param_ok_in,
  input wire logic exec_cond_in,
  input wire logic pulse_form_in,
  input wire logic [2:0] op_sel_in,
  input wire logic [15:0] src_a_in,
  input wire logic [15:0] src_b_in,
  input wire logic [2:0] digits_a_in,
  input wire logic [2:0] digits_b_in,
  input wire logic [15:0] step_in,
  input wire logic end_of_scan_in,
  input wire logic end_misread_in,
  output logic [15:0] result_out,
  output logic result_we_out,
  output logic running_out,
  output logic [15:0] error_code_reg_out,
  output logic [15:0] error_step_reg_out,
  output logic error_flag_out
);
  plc_word_logic_pkg::run_state_t state_reg;
  plc_word_logic_pkg::run_state_t state_next;
  logic cond_prev_reg;
  logic [15:0] scan_cnt_reg;
  logic [15:0] a_masked;
  logic [15:0] b_masked;
  logic fire;
  logic [15:0] calc;
  logic is_run;
  logic enter_run;
  logic [15:0] err_code;
  logic err_hit;

  // Keep only the designated nibbles of an operand
  function automatic logic [15:0] digit_mask(input logic [15:0] w, input logic [2:0] d);
    logic [15:0] m;
    m = plc_word_logic_pkg::WORD_ZERO;
    for (int i = 0; i < plc_word_logic_pkg::WORD_W; i++)
    begin
      m[i] = ((i / plc_word_logic_pkg::NIBBLE_W) < int'(d));
    end
    return w & m;
  endfunction : digit_mask

  assign is_run = (state_reg == plc_word_logic_pkg::ST_RUN);
  // Only a stopped unit may start; a halted one must see the run request drop first
  assign enter_run = (state_reg == plc_word_logic_pkg::ST_STOP) && run_req_in && param_ok_in;
  assign running_out = is_run;

  // Operand masking
  assign a_masked = digit_mask(src_a_in, digits_a_in);
  assign b_masked = digit_mask(src_b_in, digits_b_in);

  // Plain form on level, pulse form on rising edge
  assign fire = is_run && exec_cond_in && (!pulse_form_in || !cond_prev_reg);

  // Datapath
  always_comb
  begin
    calc = plc_word_logic_pkg::WORD_ZERO;
    case (op_sel_in)
      plc_word_logic_pkg::OP_XNOR2: calc = ~(a_masked ^ b_masked);
      plc_word_logic_pkg::OP_XNOR3: calc = ~(a_masked ^ b_masked);
      plc_word_logic_pkg::OP_NEGATE: calc = 16'(~a_masked + 16'h0001);
      default: calc = plc_word_logic_pkg::WORD_ZERO;
    endcase
  end

  // Error detection: parameter check in stop first, then run errors with low code first
  always_comb
  begin
    err_hit = 1'b0;
    err_code = plc_word_logic_pkg::ERR_NONE;
    if ((state_reg == plc_word_logic_pkg::ST_STOP) && run_req_in && !param_ok_in)
    begin
      err_hit = 1'b1;
      err_code = plc_word_logic_pkg::ERR_PARAMETER;
    end
    else if (is_run && exec_cond_in && op_sel_in == plc_word_logic_pkg::OP_BAD)
    begin
      err_hit = 1'b1;
      err_code = plc_word_logic_pkg::ERR_UNDECODABLE;
    end
    else if (is_run && end_of_scan_in && scan_cnt_reg > 16'(WDT_LIMIT))
    begin
      err_hit = 1'b1;
      err_code = plc_word_logic_pkg::ERR_SCAN_OVERRUN;
    end
    else if (is_run && end_misread_in)
    begin
      err_hit = 1'b1;
      err_code = plc_word_logic_pkg::ERR_MISSING_END;
    end
  end

  // Run state machine
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      plc_word_logic_pkg::ST_STOP:
      begin
        if (err_hit)
          state_next = plc_word_logic_pkg::ST_HALT;
        else if (enter_run)
          state_next = plc_word_logic_pkg::ST_RUN;
      end
      plc_word_logic_pkg::ST_RUN:
      begin
        if (err_hit || !run_req_in)
          state_next = (err_hit) ? plc_word_logic_pkg::ST_HALT : plc_word_logic_pkg::ST_STOP;
      end
      plc_word_logic_pkg::ST_HALT:
      begin
        if (!run_req_in)
          state_next = plc_word_logic_pkg::ST_STOP;
      end
      default: state_next = plc_word_logic_pkg::ST_STOP;
    endcase
  end

  // State register
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
      state_reg <= plc_word_logic_pkg::ST_STOP;
    else
      state_reg <= state_next;
  end

  // Execution condition history
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
      cond_prev_reg <= 1'b0;
    else
      cond_prev_reg <= exec_cond_in;
  end

  // Scan time counter, saturating
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
      scan_cnt_reg <= plc_word_logic_pkg::WORD_ZERO;
    else if (!is_run || end_of_scan_in)
      scan_cnt_reg <= plc_word_logic_pkg::WORD_ZERO;
    else if (scan_cnt_reg != 16'hFFFF)
      scan_cnt_reg <= 16'(scan_cnt_reg + 16'h0001);
  end

  // Result write port
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      result_out <= plc_word_logic_pkg::WORD_ZERO;
      result_we_out <= 1'b0;
    end
    else
    begin
      result_we_out <= fire && (op_sel_in inside {plc_word_logic_pkg::OP_XNOR2,
        plc_word_logic_pkg::OP_XNOR3, plc_word_logic_pkg::OP_NEGATE}) && !err_hit;
      if (fire)
        result_out <= calc;
    end
  end

  // Error capture, first error held; a failed start attempt records afresh
  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      error_code_reg_out <= plc_word_logic_pkg::ERR_NONE;
      error_step_reg_out <= plc_word_logic_pkg::STEP_ZERO;
      error_flag_out <= 1'b0;
    end
    else if (err_hit && (!error_flag_out || state_reg == plc_word_logic_pkg::ST_STOP))
    begin
      error_code_reg_out <= err_code;
      error_step_reg_out <= step_in;
      error_flag_out <= 1'b1;
    end
    else if (enter_run && !err_hit)
    begin
      error_code_reg_out <= plc_word_logic_pkg::ERR_NONE;
      error_step_reg_out <= plc_word_logic_pkg::STEP_ZERO;
      error_flag_out <= 1'b0;
    end
  end

  property p_xnor_result;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    fire && !err_hit && op_sel_in == plc_word_logic_pkg::OP_XNOR3
    |=> result_we_out && result_out == ~($past(a_masked) ^ $past(b_masked));
  endproperty
  a_xnor_result: assert property (p_xnor_result) else $error("xnor result wrong");

  property p_xnor2_result;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    fire && !err_hit && op_sel_in == plc_word_logic_pkg::OP_XNOR2
    |=> result_out == ~($past(a_masked) ^ $past(b_masked));
  endproperty
  a_xnor2_result: assert property (p_xnor2_result) else $error("xnor2 result wrong");

  property p_mask;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    digits_a_in == 3'h1 |-> a_masked[15:4] == 12'h000;
  endproperty
  a_mask: assert property (p_mask) else $error("upper digits not zero");

  property p_negate;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    fire && !err_hit && op_sel_in == plc_word_logic_pkg::OP_NEGATE
    |=> 16'(result_out + $past(a_masked)) == 16'h0000;
  endproperty
  a_negate: assert property (p_negate) else $error("negate wrong");

  property p_pulse_once;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    pulse_form_in && $past(exec_cond_in) |-> !fire;
  endproperty
  a_pulse_once: assert property (p_pulse_once) else $error("pulse form repeated");

  property p_undecodable;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    is_run && exec_cond_in && op_sel_in == plc_word_logic_pkg::OP_BAD && !error_flag_out
    |=> error_code_reg_out == plc_word_logic_pkg::ERR_UNDECODABLE && !running_out
      && error_step_reg_out == $past(step_in);
  endproperty
  a_undecodable: assert property (p_undecodable) else $error("code 10 not recorded");

  property p_param;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    state_reg == plc_word_logic_pkg::ST_STOP && run_req_in && !param_ok_in
    |=> error_code_reg_out == plc_word_logic_pkg::ERR_PARAMETER && error_flag_out && !running_out;
  endproperty
  a_param: assert property (p_param) else $error("code 11 not recorded");

  property p_wdt;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    err_hit && err_code == plc_word_logic_pkg::ERR_SCAN_OVERRUN && !error_flag_out
    |=> error_code_reg_out == plc_word_logic_pkg::ERR_SCAN_OVERRUN ##1 !running_out;
  endproperty
  a_wdt: assert property (p_wdt) else $error("code 22 not recorded");

  property p_missing_end;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    err_hit && err_code == plc_word_logic_pkg::ERR_MISSING_END && !error_flag_out
    |=> error_code_reg_out == plc_word_logic_pkg::ERR_MISSING_END && !running_out;
  endproperty
  a_missing_end: assert property (p_missing_end) else $error("code 24 not recorded");

  property p_hold;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    error_flag_out && !(state_reg == plc_word_logic_pkg::ST_STOP && run_req_in)
    |=> $stable(error_code_reg_out) && $stable(error_step_reg_out);
  endproperty
  a_hold: assert property (p_hold) else $error("error record changed");

  property p_flag;
    @(posedge clk_sys_in) disable iff (!nrst_in)
    $rose(error_flag_out) |-> error_code_reg_out != plc_word_logic_pkg::ERR_NONE && !running_out;
  endproperty
  a_flag: assert property (p_flag) else $error("flag without code");
endmodule : plc_word_logic_and_error_unit

// ---- bench/plc_word_logic_and_error_unit_test.sv ----
// Purpose: Self-checking bench for the word logic and error unit
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Watchdog limit shortened to 10 cycles
`timescale 1ns/1ps
module plc_word_logic_and_error_unit_test;
  localparam int WDT = 10;
  logic clk_sys_in, nrst_in, run_req_in, param_ok_in, exec_cond_in, pulse_form_in;
  logic [2:0] op_sel_in, digits_a_in, digits_b_in;
  logic [15:0] src_a_in, src_b_in, step_in, result_out, error_code_reg_out, error_step_reg_out;
  logic end_of_scan_in, end_misread_in, result_we_out, running_out, error_flag_out;
  int failures, n_compared;

  // Unit under test
  plc_word_logic_and_error_unit #(.WDT_LIMIT(WDT)) uut (.clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in), .run_req_in(run_req_in), .param_ok_in(param_ok_in),
    .exec_cond_in(exec_cond_in), .pulse_form_in(pulse_form_in), .op_sel_in(op_sel_in),
    .src_a_in(src_a_in), .src_b_in(src_b_in), .digits_a_in(digits_a_in),
    .digits_b_in(digits_b_in), .step_in(step_in), .end_of_scan_in(end_of_scan_in),
    .end_misread_in(end_misread_in), .result_out(result_out), .result_we_out(result_we_out),
    .running_out(running_out), .error_code_reg_out(error_code_reg_out),
    .error_step_reg_out(error_step_reg_out), .error_flag_out(error_flag_out));

  // Free-running 100 MHz clock
  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  task automatic tick(input int n);
    repeat (n)
    begin
      @(posedge clk_sys_in);
      #1;
    end
  endtask : tick

  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic test_done();
    $display("failures %0d compared %0d", failures, n_compared);
    if (failures == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : test_done

  // Stop, then request run with good parameters; bounded wait for run
  task automatic start_run();
    run_req_in = 1'b0;
    tick(2);
    param_ok_in = 1'b1;
    run_req_in = 1'b1;
    for (int i = 0; i < 10 && running_out !== 1'b1; i++)
      tick(1);
    chk_bit("running", 1'b1, running_out);
    if (running_out !== 1'b1)
      test_done();
    chk_word("code clear", plc_word_logic_pkg::ERR_NONE, error_code_reg_out);
    chk_bit("flag clear", 1'b0, error_flag_out);
  endtask : start_run

  // Plain form executes on two back-to-back scans, then strobe drops
  task automatic exec_op(input logic [2:0] sel, input logic [15:0] a, input logic [15:0] b,
    input logic [2:0] da, input logic [2:0] db, input logic [15:0] exp);
    op_sel_in = sel;
    src_a_in = a;
    src_b_in = b;
    digits_a_in = da;
    digits_b_in = db;
    exec_cond_in = 1'b1;
    pulse_form_in = 1'b0;
    repeat (2)
    begin
      tick(1);
      chk_bit("we", 1'b1, result_we_out);
      chk_word("result", exp, result_out);
    end
    exec_cond_in = 1'b0;
    tick(2);
    chk_bit("we off", 1'b0, result_we_out);
  endtask : exec_op

  task automatic err_chk(input logic [15:0] code);
    chk_word("code", code, error_code_reg_out);
    chk_bit("flag", 1'b1, error_flag_out);
    chk_bit("stopped", 1'b0, running_out);
  endtask : err_chk

  // Pulse form fires once per rising condition
  task automatic pulse_test();
    op_sel_in = 3'h3;
    src_a_in = 16'h0005;
    digits_a_in = 3'h4;
    pulse_form_in = 1'b1;
    exec_cond_in = 1'b1;
    tick(1);
    chk_bit("pulse we", 1'b1, result_we_out);
    chk_word("pulse result", 16'hFFFB, result_out);
    tick(1);
    chk_bit("pulse held", 1'b0, result_we_out);
    exec_cond_in = 1'b0;
    tick(1);
    exec_cond_in = 1'b1;
    tick(1);
    chk_bit("pulse refire", 1'b1, result_we_out);
    exec_cond_in = 1'b0;
    tick(1);
  endtask : pulse_test

  // Undecodable code stops, then holds against later faults
  task automatic bad_op_test();
    op_sel_in = 3'h7;
    step_in = 16'h0123;
    exec_cond_in = 1'b1;
    pulse_form_in = 1'b0;
    tick(2);
    exec_cond_in = 1'b0;
    err_chk(plc_word_logic_pkg::ERR_UNDECODABLE);
    chk_word("step", 16'h0123, error_step_reg_out);
    step_in = 16'h0999;
    end_misread_in = 1'b1;
    op_sel_in = 3'h1;
    exec_cond_in = 1'b1;
    tick(1);
    end_misread_in = 1'b0;
    tick(2);
    chk_bit("halt no exec", 1'b0, result_we_out);
    chk_word("code held", plc_word_logic_pkg::ERR_UNDECODABLE, error_code_reg_out);
    chk_word("step held", 16'h0123, error_step_reg_out);
    exec_cond_in = 1'b0;
  endtask : bad_op_test

  // Watchdog: short scan passes, long scan stops
  task automatic wdt_test();
    tick(3);
    end_of_scan_in = 1'b1;
    tick(1);
    end_of_scan_in = 1'b0;
    tick(1);
    chk_word("short scan", plc_word_logic_pkg::ERR_NONE, error_code_reg_out);
    tick(WDT + 4);
    end_of_scan_in = 1'b1;
    tick(1);
    end_of_scan_in = 1'b0;
    tick(1);
    err_chk(plc_word_logic_pkg::ERR_SCAN_OVERRUN);
  endtask : wdt_test

  // Main sequence
  initial
  begin
    failures = 0;
    n_compared = 0;
    {run_req_in, param_ok_in, exec_cond_in, pulse_form_in, end_of_scan_in} = '0;
    {op_sel_in, digits_a_in, digits_b_in, end_misread_in} = '0;
    {src_a_in, src_b_in, step_in} = '0;
    nrst_in = 1'b0;
    repeat (6) @(posedge clk_sys_in);
    #1;
    nrst_in = 1'b1;
    chk_bit("reset run", 1'b0, running_out);
    start_run();
    exec_op(3'h1, 16'h00FF, 16'h0F0F, 3'h4, 3'h4, 16'hF00F);
    exec_op(3'h2, 16'h1234, 16'hFFFF, 3'h4, 3'h4, 16'h1234);
    exec_op(3'h1, 16'hABCD, 16'h0005, 3'h1, 3'h4, 16'hFFF7);
    exec_op(3'h3, 16'h1234, 16'h0000, 3'h2, 3'h4, 16'hFFCC);
    exec_op(3'h3, 16'hFFFF, 16'h0000, 3'h4, 3'h4, 16'h0001);
    pulse_test();
    bad_op_test();
    start_run();
    step_in = 16'h0044;
    end_misread_in = 1'b1;
    tick(1);
    end_misread_in = 1'b0;
    tick(1);
    err_chk(plc_word_logic_pkg::ERR_MISSING_END);
    chk_word("step end", 16'h0044, error_step_reg_out);
    start_run();
    wdt_test();
    run_req_in = 1'b0;
    tick(2);
    param_ok_in = 1'b0;
    run_req_in = 1'b1;
    tick(3);
    err_chk(plc_word_logic_pkg::ERR_PARAMETER);
    // Reset while halted clears the held record
    nrst_in = 1'b0;
    tick(1);
    chk_word("reset code", plc_word_logic_pkg::ERR_NONE, error_code_reg_out);
    chk_word("reset step", plc_word_logic_pkg::STEP_ZERO, error_step_reg_out);
    chk_bit("reset flag", 1'b0, error_flag_out);
    nrst_in = 1'b1;
    start_run();
    test_done();
  end
endmodule : plc_word_logic_and_error_unit_test
